//--- logic/bscrc_top.sv
// APB slave holding the CRC input and result registers
`timescale 1ns/1ps
`default_nettype none
`include "bscrc_consts.svh"
module bscrc_top (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire bscrc_pkg::bscrc_apb_req_t apb_req,
  output var  bscrc_pkg::bscrc_apb_rsp_t apb_rsp
);
  import bscrc_pkg::*;

  // Register state and next values
  logic [7:0]  byte_q;
  logic [7:0]  byte_d;
  logic [15:0] rem_q;
  logic [15:0] rem_d;
  logic [15:0] rem_fold;
  logic        ready_q;
  logic        ready_d;
  logic        err_q;
  logic        err_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Bus phase decode
  wire logic        setup_ph;
  wire logic        access_ph;
  wire logic        xfer_done;
  wire logic        is_wr;
  wire logic        is_rd;
  wire logic        wr_req;
  wire logic        rd_req;
  wire logic        stray;

  // Address and byte lane decode
  wire logic        hit_in;
  wire logic        hit_rem;
  wire logic        mapped;
  wire logic        lanes_in;
  wire logic        lanes_rem;
  wire logic        wr_in;
  wire logic        wr_rem;

  // Read path
  wire logic [31:0] rd_in_word;
  wire logic [31:0] rd_rem_word;
  wire logic [31:0] rd_mux;

  // Remainder update paths
  wire logic [15:0] rem_preset;
  wire logic [15:0] rem_next;

  // Exact match of a byte address against a register offset
  function automatic logic addr_hit(
    input logic [11:0] addr,
    input logic [11:0] ofs
  );
    logic hit;
    hit = (addr == ofs);
    return hit;
  endfunction

  // Every lane named in need must be on; extra lanes are harmless
  function automatic logic lanes_ok(
    input logic [3:0] strb,
    input logic [3:0] need
  );
    logic ok;
    ok = ((strb & need) == need);
    return ok;
  endfunction

  // Unused upper bits of a read word are always zero
  function automatic logic [31:0] zext8(
    input logic [7:0] v
  );
    logic [31:0] w;
    w = {24'h000000, v};
    return w;
  endfunction

  function automatic logic [31:0] zext16(
    input logic [15:0] v
  );
    logic [31:0] w;
    w = {16'h0000, v};
    return w;
  endfunction

  // A transfer completes at the edge where the access phase sees pready
  assign setup_ph  = apb_req.psel & ~apb_req.penable;
  assign access_ph = apb_req.psel & apb_req.penable;
  assign xfer_done = access_ph & ready_q;
  assign is_wr     = apb_req.pwrite;
  assign is_rd     = ~apb_req.pwrite;
  assign wr_req    = xfer_done & is_wr;
  assign rd_req    = setup_ph & is_rd;
  assign stray     = setup_ph & ~mapped;

  assign hit_in    = addr_hit(apb_req.paddr, `BSCRC_OFS_BYTE_INPUT);
  assign hit_rem   = addr_hit(apb_req.paddr, `BSCRC_OFS_REMAINDER);
  assign mapped    = hit_in | hit_rem;

  // Partial-lane writes are dropped quietly rather than flagged
  assign lanes_in  = lanes_ok(apb_req.pstrb, `BSCRC_LANES_BYTE);
  assign lanes_rem = lanes_ok(apb_req.pstrb, `BSCRC_LANES_REM);
  assign wr_in     = wr_req & hit_in & lanes_in;
  assign wr_rem    = wr_req & hit_rem & lanes_rem;

  assign rd_in_word  = zext8(byte_q);
  assign rd_rem_word = zext16(rem_q);
  assign rd_mux      = hit_in  ? rd_in_word :
                       hit_rem ? rd_rem_word : `BSCRC_RST_RDATA;

  bscrc_fold bscrc_fold_inst (
    .rem_in  (rem_q),
    .data_in (apb_req.pwdata[7:0]),
    .rem_out (rem_fold)
  );

  // Lane 0 carries the input byte into the register and the fold
  assign byte_d = wr_in ? apb_req.pwdata[7:0] : byte_q; // RL3

  // Preset and fold never coincide: they decode different offsets
  assign rem_preset = apb_req.pwdata[15:0]; // RL4 RL7
  assign rem_next   = rem_fold; // RL2 RL9
  assign rem_d      = wr_rem ? rem_preset :
                      wr_in  ? rem_next : rem_q; // RL12

  // Read data is taken at the setup edge, after any earlier write has
  // landed, so a read right after a byte write sees the new remainder
  assign ready_d = setup_ph;
  assign err_d   = stray;
  assign rdata_d = rd_req ? rd_mux : `BSCRC_RST_RDATA; // RL12

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      byte_q <= `BSCRC_RST_BYTE_INPUT; // RL3
    end else begin
      byte_q <= byte_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rem_q <= `BSCRC_RST_REMAINDER; // RL4
    end else begin
      rem_q <= rem_d; // RL2
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= ready_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      err_q <= 1'b0;
    end else begin
      err_q <= err_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= `BSCRC_RST_RDATA;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // All response fields come straight from flops
  assign apb_rsp = '{pready: ready_q, prdata: rdata_q, pslverr: err_q};
endmodule
`default_nettype wire

//--- logic/bscrc_consts.svh
// Constants for the byte serial CRC16 engine
// What this block does
// (RL1) Computes a 16-bit code with x^16+x^12+x^5+1, fed one byte at a time.
// (RL2) Each byte write folds the byte in and replaces the result register.
// (RL3) Input register is 8 bits, read and write, reset to 00h.
// (RL4) Result register is 16 bits, read and write; a write presets it; reset 0000h.
// (RL5) Bytes are processed least significant bit first; 01h from zero gives 1189h.
// (RL6) Division is modulo 2: add and subtract are exclusive-OR.
// (RL7) Software presets the result register to 0000h before each block.
// (RL8) Sender transmits the result low byte first, then high byte.
// (RL9) Receiver feeds all bytes plus code; 0000h means no error.
// (RL10) Software avoids the result register under certain slow clock modes.
// (RL11) Eight right shifts per byte, XOR with 8408h when low bit differs.
// (RL12) The update completes in the write cycle; the next read sees it.
`ifndef BSCRC_CONSTS_SVH
`define BSCRC_CONSTS_SVH
`define BSCRC_OFS_BYTE_INPUT 12'h000
`define BSCRC_OFS_REMAINDER  12'h004
`define BSCRC_RST_BYTE_INPUT 8'h00
`define BSCRC_RST_REMAINDER  16'h0000
`define BSCRC_POLY_REFLECTED 16'h8408
`define BSCRC_LANES_BYTE     4'h1
`define BSCRC_LANES_REM      4'h3
`define BSCRC_RST_RDATA      32'h00000000
`define BSCRC_ADDR_W         12
`endif

//--- logic/bscrc_pkg.sv
// Types for the byte serial CRC16 engine
package bscrc_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } bscrc_apb_req_t;
  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } bscrc_apb_rsp_t;
endpackage

//--- logic/bscrc_fold.sv
// Combinational fold of one byte into the CRC remainder
`timescale 1ns/1ps
`default_nettype none
`include "bscrc_consts.svh"
module bscrc_fold (
  input  wire logic [15:0] rem_in,
  input  wire logic [7:0]  data_in,
  output logic      [15:0] rem_out
);
  function automatic logic [15:0] fold_byte(input logic [15:0] r,
                                            input logic [7:0]  d);
    logic [15:0] acc;
    acc = r;
    for (int i = 0; i < 8; i++) begin // RL5 RL11
      if (acc[0] ^ d[i]) begin
        acc = (acc >> 1) ^ `BSCRC_POLY_REFLECTED; // RL6 RL1
      end else begin
        acc = acc >> 1;
      end
    end
    return acc;
  endfunction
  assign rem_out = fold_byte(rem_in, data_in);
endmodule
`default_nettype wire

//--- verification/bscrc_sva.sv
// Bus timing and read data assertions for the CRC engine
`timescale 1ns/1ps
`default_nettype none
`include "bscrc_consts.svh"
module bscrc_sva (
  input wire logic                      clk,
  input wire logic                      resetn,
  input wire bscrc_pkg::bscrc_apb_req_t apb_req,
  input wire bscrc_pkg::bscrc_apb_rsp_t apb_rsp
);
  import bscrc_pkg::*;
  wire setup = apb_req.psel & ~apb_req.penable;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_rdy; setup |=> apb_rsp.pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  property p_one; apb_rsp.pready |=> !apb_rsp.pready; endproperty
  a_one: assert property (p_one) else $error("ready long");
  property p_hi; apb_rsp.pready |-> apb_rsp.prdata[31:16] == 16'h0;
  endproperty
  a_hi: assert property (p_hi) else $error("upper data set");
  property p_err; apb_rsp.pslverr |-> apb_rsp.pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_idle; !apb_req.psel |=> !apb_rsp.pready; endproperty
  a_idle: assert property (p_idle) else $error("ready when idle");
  property p_wrz;
    (apb_rsp.pready && apb_req.pwrite) |-> apb_rsp.prdata == 32'h0;
  endproperty
  a_wrz: assert property (p_wrz) else $error("data on write");
  property p_byte;
    (apb_rsp.pready && !apb_req.pwrite &&
     apb_req.paddr == `BSCRC_OFS_BYTE_INPUT) |->
      apb_rsp.prdata[31:8] == 24'h0 && !apb_rsp.pslverr;
  endproperty
  a_byte: assert property (p_byte) else $error("input read wide");
endmodule
bind bscrc_top bscrc_sva bscrc_sva_inst (.clk(clk), .resetn(resetn),
  .apb_req(apb_req), .apb_rsp(apb_rsp));
`default_nettype wire

//--- verification/testbench.sv
// Register level bench for the CRC engine
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bscrc_pkg::*;
  logic clk = 0, resetn = 0, se;
  bscrc_apb_req_t rq = '0;
  bscrc_apb_rsp_t rs;
  int err_total = 0, comparisons = 0;
  logic [31:0] r, c;
  logic [15:0] x, y;
  logic [3:0] st = 4'hf;
  logic [7:0] m [4] = '{8'h78, 8'h56, 8'h34, 8'h12};
  bscrc_top bscrc_top_inst (.clk(clk), .resetn(resetn), .apb_req(rq),
    .apb_rsp(rs));
  initial forever #50 clk = ~clk;
  function automatic logic [15:0] f(logic [15:0] v, logic [7:0] b);
    for (int i = 0; i < 8; i++) v = (v[0] ^ b[i]) ? (v >> 1) ^ 16'h8408
      : v >> 1;
    return v;
  endfunction
  task automatic xf(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk) rq <= '{1'b1, 1'b0, w, a, d, st};
    @(posedge clk) rq.penable <= 1'b1;
    do @(posedge clk); while (rs.pready !== 1'b1);
    r = rs.prdata;
    se = rs.pslverr;
    rq <= '0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #100000 err_total++;
    summarize;
  end
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    xf(0, 0, 0); chk(r, 0);
    xf(0, 4, 0); chk(r, 0);
    xf(1, 4, 0); xf(1, 0, 1); xf(0, 4, 0); chk(r, 32'h1189);
    xf(1, 4, 0);
    x = 0;
    foreach (m[i]) begin
      xf(1, 0, m[i]);
      x = f(x, m[i]);
    end
    xf(0, 0, 0); chk(r, 32'h12);
    xf(0, 4, 0); chk(r, x);
    c = r;
    xf(1, 0, c[7:0]); xf(1, 0, c[15:8]); xf(0, 4, 0); chk(r, 0);
    chk(se, 0);
    xf(1, 4, 0); y = 0;
    foreach (m[i]) begin
      xf(1, 0, m[i] ^ (i == 0));
      y = f(y, m[i] ^ (i == 0));
    end
    xf(1, 0, c[7:0]); xf(1, 0, c[15:8]); xf(0, 4, 0);
    y = f(f(y, c[7:0]), c[15:8]);
    chk(r, y); chk(r == 0, 0);
    xf(1, 4, 32'habcd); xf(0, 4, 0); chk(r, 32'habcd);
    st = 4'h2; xf(1, 0, 8'h5a); xf(1, 4, 0); st = 4'hf;
    xf(0, 0, 0); chk(r, c[15:8]);
    xf(0, 4, 0); chk(r, 32'habcd);
    @(posedge clk) resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    xf(0, 0, 0); chk(r, 0);
    xf(0, 4, 0); chk(r, 0);
    xf(0, 12'h008, 0); chk(se, 1);
    summarize;
  end
endmodule
`default_nettype wire
